// file: verilog/loader_pkg.sv
// Shared constants for the program load controller
package loader_pkg;
  // --------------------------------------------------------------
  // Clock and serial timing
  // --------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int BAUD_FAST   = 57600;
  localparam int BAUD_SLOW   = 300;
  localparam int BIT_MIN_CYC = CLK_HZ / BAUD_FAST;
  localparam int BIT_MAX_CYC = CLK_HZ / BAUD_SLOW;
  // --------------------------------------------------------------
  // Parallel cycle codes on port 2 bits 7 and 6
  // --------------------------------------------------------------
  localparam logic [1:0] CYC_VERIFY  = 2'h0;
  localparam logic [1:0] CYC_EXT     = 2'h1;
  localparam logic [1:0] CYC_PROGRAM = 2'h2;
  localparam logic [1:0] CYC_SECURE  = 2'h3;
  // Absolute register addresses seen by the register cycles
  localparam logic [7:0] REG_MEMORY_CONTROL_REG    = 8'h00;
  localparam logic [7:0] REG_KEY0    = 8'h01;
  localparam int         KEY_BYTES   = 5;
  // --------------------------------------------------------------
  // Memory control register layout
  // --------------------------------------------------------------
  localparam int         LOCK_BIT    = 0;
  localparam logic [7:0] MEMORY_CONTROL_REG_RESET  = 8'h00;
  localparam logic [7:0] MEMORY_CONTROL_REG_MASK   = 8'hF8;
  localparam logic [7:0] MEMORY_CONTROL_REG_BOOT   = 8'h20;
  // --------------------------------------------------------------
  // Loader characters
  // --------------------------------------------------------------
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_PROMPT = 8'h3E;
  localparam logic [7:0] CH_BAD    = 8'h3F;
  localparam logic [7:0] CH_FAIL   = 8'h21;
  localparam logic [7:0] CH_NONE   = 8'h00;
  localparam logic [7:0] CMD_CRC   = 8'h43;
  localparam logic [7:0] CMD_DUMP  = 8'h44;
  localparam logic [7:0] CMD_FILL  = 8'h46;
  localparam logic [7:0] CMD_KEY   = 8'h4B;
  localparam logic [7:0] CMD_LOAD  = 8'h4C;
  localparam logic [7:0] CMD_RMCON = 8'h52;
  localparam logic [7:0] CMD_TRACE = 8'h54;
  localparam logic [7:0] CMD_UNLK  = 8'h55;
  localparam logic [7:0] CMD_VER   = 8'h56;
  localparam logic [7:0] CMD_WMCON = 8'h57;
  localparam logic [7:0] CMD_LOCK  = 8'h53;
  localparam logic [7:0] CMD_PUT   = 8'h50;
  localparam logic [7:0] CMD_GET   = 8'h47;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'hA001;
endpackage

// file: verilog/load_ram.sv
// Nonvolatile program/data store with registered read
`timescale 1ns/10ps
module load_ram #(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 8
) (
  // Clock
  input  wire logic              ref_clk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// file: verilog/program_load_controller.sv
// Program load controller: parallel programming cycles and serial loader
//
// Notes on behaviour
// R1: Load mode: reset high, strobe pulled low.
// R2: Then parallel pulse or serial CR picks path.
// R3: Port2 7/6 pick program, secure, verify.
// R4: Code 0/1: bit5 picks expanded or register.
// R5: Program writes byte; verify returns it.
// R6: Register cycles use absolute address, port2 00H.
// R7: Memory control register readable by verify.
// R8: First strobe sets 8K range, 4K split.
// R9: Expanded cycles reach 32K, take longer.
// R10: Security cycle or control bit0 locks.
// R11: Programmer order: control, keys, program, lock.
// R12: Serial loading keeps port2 7/6 high; the serial path never checks port2.
// R13: Serial uses receive and transmit only.
// R14: Loader baud between 300 and 57600; a 300 baud start bit saturates cnt at BIT_MAX and is rejected.
// R15: Load, dump and verify RAM contents.
// R16: Single-character loader command set.
// R17: Unknown command answers an error character.
// R18: Baud taken from first CR start bit.
`timescale 1ns/10ps
module program_load_controller
  import loader_pkg::*;
#(
  parameter int ADDR_W  = 15,
  parameter int BIT_MAX = BIT_MAX_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Load entry pins
  input  wire logic        reset_pin,
  input  wire logic        program_store_strobe_n,
  input  wire logic        prog_pulse_n,
  input  wire logic        external_access_sel,
  input  wire logic        programming_voltage,
  // Parallel ports
  input  wire logic [7:0]  port2_in,
  input  wire logic [7:0]  port1_in,
  input  wire logic [7:0]  port0_in,
  output logic      [7:0]  port0_out,
  output logic             port0_oe,
  // Serial link
  input  wire logic        rxd,
  output logic             txd,
  // Status
  output logic             load_mode,
  output logic             serial_active,
  output logic             parallel_active,
  output logic             security_lock,
  output logic      [7:0]  memory_control_reg,
  output logic      [39:0] encryption_key,
  output logic      [7:0]  port_put_value
);
  localparam int BW = $clog2(BIT_MAX + 1) + 1;

  // Expanded addressing needs 15 bits; a lower bit limit cannot take the fastest rate
  if (ADDR_W < 15 || BIT_MAX < BIT_MIN_CYC) begin : g_bad_params
    $error("program_load_controller: bad parameters");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT, ST_SETTLE, ST_PAR, ST_CMD, ST_ARG, ST_EXEC,
    ST_CRC, ST_DUMP, ST_FILL, ST_VER, ST_EMIT
  } state_e;

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  logic [29:0] meta, sync;
  logic        prog_prev, rx_prev;
  always_ff @(posedge ref_clk) begin
    meta <= {reset_pin, program_store_strobe_n, prog_pulse_n, external_access_sel,
             programming_voltage, port2_in, port1_in, port0_in, rxd};
    sync <= meta;
    prog_prev <= sync[27];
    rx_prev   <= sync[0];
  end
  logic       rst_s, pss_n_s, prog_n_s, ext_s, vpp_s, rx_s;
  logic [7:0] p2, p1, p0;
  assign {rst_s, pss_n_s, prog_n_s, ext_s, vpp_s, p2, p1, p0, rx_s} = sync;
  logic prog_fall;
  assign prog_fall = prog_prev && !prog_n_s;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction
  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction

  // --------------------------------------------------------------
  // State, memory and loader registers
  // --------------------------------------------------------------
  state_e              st, emit_ret;
  logic [BW-1:0]       cnt, bit_period;
  logic [ADDR_W-1:0]   addr, last, hi_addr;
  logic [39:0]         arg;
  logic [7:0]          cmd, fill_val, emit_tail;
  logic [15:0]         crc, emit_val, dump_cnt;
  logic [2:0]          emit_n;
  logic                ph, trace_on, hi_have, init_done;
  logic                wr_en;
  logic [ADDR_W-1:0]   wr_addr, rd_addr;
  logic [7:0]          wr_data, rd_data;
  logic                rx_valid;
  logic [7:0]          rx_byte;
  logic                push_valid, push_ok;
  logic [7:0]          push_data;

  load_ram #(.ADDR_W(ADDR_W), .DATA_W(8)) u_ram (
    .ref_clk (ref_clk),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  logic               par_ext, par_reg;
  logic [ADDR_W-1:0]  par_addr;
  assign par_ext  = p2[7:6] == CYC_EXT && !p2[5];
  assign par_reg  = p2[7:6] == CYC_EXT && p2[5];
  assign par_addr = par_ext ? ADDR_W'({hi_addr[6:0], p1}) // R9
                            : ADDR_W'({p2[3:0], p1});
  assign rd_addr  = (st == ST_PAR) ? par_addr : addr;

  assign load_mode          = st != ST_IDLE;
  assign parallel_active    = st == ST_PAR;
  assign serial_active      = st >= ST_CMD;
  assign security_lock      = memory_control_reg[LOCK_BIT];

  task automatic go_emit(input logic [15:0] v, input logic [2:0] n,
                         input logic [7:0] t, input state_e r);
    emit_val  <= v;
    emit_n    <= n;
    emit_tail <= t;
    emit_ret  <= r;
    st        <= ST_EMIT;
  endtask

  always_ff @(posedge ref_clk) begin
    wr_en <= 1'b0;
    if (reset) begin
      st <= ST_IDLE;
      emit_ret <= ST_CMD;
      {cnt, bit_period, addr, last, hi_addr, arg, cmd, fill_val} <= '0;
      {crc, emit_val, dump_cnt, emit_n, ph, trace_on, hi_have} <= '0;
      emit_tail <= CH_NONE;
      init_done <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
      memory_control_reg <= MEMORY_CONTROL_REG_RESET;
      encryption_key <= 40'h00_0000_0000;
      port_put_value <= 8'h00;
    end else if (!rst_s) begin
      st <= ST_IDLE;
    end else begin
      case (st)
        ST_IDLE: if (!pss_n_s) st <= ST_WAIT; // R1
        ST_WAIT: begin
          if (prog_fall) st <= ST_PAR; // R2
          else if (!rx_s) cnt <= (cnt == BW'(BIT_MAX)) ? cnt : cnt + 1'b1; // R18
          else if (cnt != '0) begin
            if (cnt >= BW'(BIT_MIN_CYC) && cnt < BW'(BIT_MAX)) begin // R14
              bit_period <= cnt;
              st <= ST_SETTLE;
            end
            cnt <= '0;
          end
        end
        ST_SETTLE: begin
          // Let the rest of the carriage return pass before taking commands
          cnt <= rx_s ? cnt + 1'b1 : '0;
          if (rx_s && cnt == BW'({bit_period, 1'b0}))
            go_emit(16'h0000, 3'd0, CH_PROMPT, ST_CMD);
        end
        ST_CMD: if (rx_valid && rx_byte != CH_CR) begin // R16
          cmd <= rx_byte;
          arg <= '0;
          if (rx_byte inside {CMD_CRC, CMD_DUMP, CMD_FILL, CMD_KEY, CMD_LOAD, CMD_RMCON,
                              CMD_TRACE, CMD_UNLK, CMD_VER, CMD_WMCON, CMD_LOCK, CMD_PUT,
                              CMD_GET})
            st <= ST_ARG;
          else go_emit(16'h0000, 3'd0, CH_BAD, ST_CMD); // R17
        end
        ST_ARG: if (rx_valid) begin
          if (is_hex(rx_byte)) arg <= {arg[35:0], hex_val(rx_byte)};
          else if (rx_byte == CH_CR) st <= ST_EXEC;
        end
        ST_EXEC: begin
          ph <= 1'b0;
          case (cmd)
            CMD_CRC: begin
              addr <= '0;
              crc <= CRC_INIT;
              st <= ST_CRC;
            end
            CMD_DUMP: begin // R15
              addr <= ADDR_W'(arg[31:16]);
              dump_cnt <= arg[15:0];
              st <= security_lock ? ST_IDLE : ST_DUMP;
              if (security_lock) go_emit(16'h0000, 3'd0, CH_FAIL, ST_CMD);
            end
            CMD_FILL: begin
              addr <= ADDR_W'(arg[39:24]);
              last <= ADDR_W'(arg[23:8]);
              fill_val <= arg[7:0];
              st <= ST_FILL;
            end
            CMD_LOAD: begin // R15
              wr_en <= 1'b1;
              wr_addr <= ADDR_W'(arg[23:8]);
              wr_data <= arg[7:0];
              go_emit(16'h0000, 3'd0, CH_PROMPT, ST_CMD);
            end
            CMD_VER: begin
              addr <= ADDR_W'(arg[23:8]);
              st <= ST_VER;
            end
            CMD_KEY: begin
              encryption_key <= arg;
              go_emit(16'h0000, 3'd0, CH_PROMPT, ST_CMD);
            end
            CMD_RMCON: go_emit({memory_control_reg, 8'h00}, 3'd2, CH_PROMPT, ST_CMD);
            CMD_WMCON: begin // R10
              memory_control_reg <= arg[7:0];
              go_emit(16'h0000, 3'd0, CH_PROMPT, ST_CMD);
            end
            CMD_TRACE: begin
              trace_on <= !trace_on;
              go_emit(16'h0000, 3'd0, CH_PROMPT, ST_CMD);
            end
            CMD_LOCK, CMD_UNLK: begin
              memory_control_reg[LOCK_BIT] <= cmd == CMD_LOCK;
              go_emit(16'h0000, 3'd0, CH_PROMPT, ST_CMD);
            end
            CMD_PUT: begin
              port_put_value <= arg[7:0];
              go_emit(16'h0000, 3'd0, CH_PROMPT, ST_CMD);
            end
            default: go_emit({p1, 8'h00}, 3'd2, CH_PROMPT, ST_CMD);
          endcase
        end
        ST_CRC: begin
          ph <= !ph;
          if (ph) begin
            crc <= crc_step(crc, rd_data);
            addr <= addr + 1'b1;
            if (&addr) go_emit(crc_step(crc, rd_data), 3'd4, CH_PROMPT, ST_CMD);
          end
        end
        ST_DUMP: begin
          ph <= !ph;
          if (dump_cnt == 16'h0000) go_emit(16'h0000, 3'd0, CH_PROMPT, ST_CMD);
          else if (ph) begin
            addr <= addr + 1'b1;
            dump_cnt <= dump_cnt - 1'b1;
            go_emit({rd_data, 8'h00}, 3'd2, CH_NONE, ST_DUMP);
          end
        end
        ST_FILL: begin
          wr_en <= 1'b1;
          wr_addr <= addr;
          wr_data <= fill_val;
          addr <= addr + 1'b1;
          if (addr == last) go_emit(16'h0000, 3'd0, CH_PROMPT, ST_CMD);
        end
        ST_VER: begin
          ph <= 1'b1;
          if (ph) go_emit(16'h0000, 3'd0,
                          (rd_data == arg[7:0] && !security_lock) ? CH_PROMPT : CH_FAIL,
                          ST_CMD);
        end
        ST_EMIT: if (push_ok) begin
          if (emit_n != 3'd0) begin
            emit_n <= emit_n - 1'b1;
            emit_val <= {emit_val[11:0], 4'h0};
          end else begin
            st <= emit_ret;
          end
        end
        ST_PAR: ;
        default: st <= ST_IDLE;
      endcase
      // Parallel strobes also act on the pulse that selected parallel loading
      if ((st == ST_WAIT || st == ST_PAR) && prog_fall && !pss_n_s && vpp_s) begin
        if (!init_done && p2[7:6] inside {CYC_PROGRAM, CYC_SECURE}) begin
          init_done <= 1'b1;
          memory_control_reg <= (memory_control_reg & MEMORY_CONTROL_REG_MASK) | MEMORY_CONTROL_REG_BOOT; // R8
        end
        case (p2[7:6])
          CYC_PROGRAM: begin // R3 R5
            wr_en <= 1'b1;
            wr_addr <= par_addr;
            wr_data <= p0;
          end
          CYC_SECURE: memory_control_reg[LOCK_BIT] <= 1'b1; // R10
          CYC_EXT: begin
            if (!p2[5] && !hi_have) begin // R4 R9
              hi_addr <= ADDR_W'(p0);
              hi_have <= 1'b1;
            end else if (!p2[5]) begin
              wr_en <= 1'b1;
              wr_addr <= par_addr;
              wr_data <= p0;
              hi_have <= 1'b0;
            end else if (p1 == REG_MEMORY_CONTROL_REG) begin // R6
              memory_control_reg <= p0;
            end else if (p1 >= REG_KEY0 && p1 < REG_KEY0 + 8'(KEY_BYTES)) begin
              encryption_key[8*(p1-REG_KEY0) +: 8] <= p0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // Parallel verify drive
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port0_oe  <= 1'b0;
      port0_out <= 8'h00;
    end else begin
      port0_oe <= st == ST_PAR && ext_s &&
                  (p2[7:6] == CYC_VERIFY || (p2[7:6] == CYC_EXT && prog_n_s)); // R3 R4
      port0_out <= !par_reg ? rd_data : (p1 == REG_MEMORY_CONTROL_REG) ? memory_control_reg : 8'h00; // R5 R7
    end
  end

  // --------------------------------------------------------------
  // Serial receiver at the measured rate
  // --------------------------------------------------------------
  logic          rx_busy;
  logic [BW-1:0] rx_cnt;
  logic [3:0]    rx_bitn;
  always_ff @(posedge ref_clk) begin
    rx_valid <= 1'b0;
    if (reset || !serial_active) begin
      rx_busy <= 1'b0;
      rx_cnt  <= '0;
      rx_bitn <= 4'h0;
      rx_byte <= 8'h00;
    end else if (!rx_busy) begin
      if (rx_prev && !rx_s) begin // R13
        rx_busy <= 1'b1;
        rx_cnt  <= bit_period >> 1;
        rx_bitn <= 4'h0;
      end
    end else if (rx_cnt != '0) begin
      rx_cnt <= rx_cnt - 1'b1;
    end else begin
      rx_cnt  <= bit_period - 1'b1;
      rx_bitn <= rx_bitn + 1'b1;
      if (rx_bitn == 4'h0 && rx_s) rx_busy <= 1'b0;
      else if (rx_bitn == 4'h9) begin
        rx_busy  <= 1'b0;
        rx_valid <= rx_s;
      end else if (rx_bitn != 4'h0) rx_byte <= {rx_s, rx_byte[7:1]};
    end
  end

  // --------------------------------------------------------------
  // Two-entry transmit buffer; a full buffer stalls loader replies and drops trace echoes
  // --------------------------------------------------------------
  logic [7:0] buf_q [0:1];
  logic       wr_ptr, rd_ptr, pop;
  logic [1:0] fill;
  assign push_valid = st == ST_EMIT || ((st == ST_CMD || st == ST_ARG) && rx_valid && trace_on);
  assign push_data  = st != ST_EMIT ? rx_byte :
                      emit_n != 3'd0 ? hex_char(emit_val[15:12]) : emit_tail;
  // An empty tail is consumed without being queued
  assign push_ok    = push_valid && (fill != 2'd2 || (st == ST_EMIT && push_data == CH_NONE));
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'd0;
      buf_q[0] <= 8'h00;
      buf_q[1] <= 8'h00;
    end else begin
      if (push_ok && push_data != CH_NONE) begin
        buf_q[wr_ptr] <= push_data;
        wr_ptr <= !wr_ptr;
      end
      if (pop) rd_ptr <= !rd_ptr;
      fill <= 2'(fill + 2'(push_ok && push_data != CH_NONE) - 2'(pop));
    end
  end

  // --------------------------------------------------------------
  // Serial transmitter
  // --------------------------------------------------------------
  logic [9:0]    tx_shift;
  logic [BW-1:0] tx_cnt;
  logic [3:0]    tx_bitn;
  assign pop = tx_bitn == 4'h0 && fill != 2'd0;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_shift <= 10'h3FF;
      tx_cnt   <= '0;
      tx_bitn  <= 4'h0;
      txd      <= 1'b1;
    end else if (pop) begin
      // One step more than the ten bits, so the stop bit lasts a full period
      tx_shift <= {1'b1, buf_q[rd_ptr], 1'b0};
      tx_cnt   <= '0;
      tx_bitn  <= 4'hB;
    end else if (tx_bitn != 4'h0) begin
      if (tx_cnt == '0) begin
        txd      <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_cnt   <= bit_period - 1'b1;
        tx_bitn  <= tx_bitn - 1'b1;
      end else begin
        tx_cnt <= tx_cnt - 1'b1;
      end
    end
  end
endmodule

// file: sim/program_load_controller_asserts.sv
// Port-level assertions for the program load controller
`timescale 1ns/10ps
module program_load_controller_chk (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        reset_pin,
  input wire logic        program_store_strobe_n,
  input wire logic        external_access_sel,
  input wire logic        txd,
  input wire logic        port0_oe,
  input wire logic        load_mode,
  input wire logic        serial_active,
  input wire logic        parallel_active,
  input wire logic        security_lock,
  input wire logic [7:0]  memory_control_reg,
  input wire logic [39:0] encryption_key
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_lock_mirrors_bit: assert property (security_lock == memory_control_reg[0])
    else $error("lock output differs from control bit 0");
  chk_one_path: assert property (!(serial_active && parallel_active))
    else $error("serial and parallel paths both active");
  chk_idle_no_path: assert property (!load_mode |-> !serial_active && !parallel_active)
    else $error("load path active outside load mode");
  chk_entry_needs_pins: assert property ($rose(load_mode) |->
      $past(reset_pin, 3) && !$past(program_store_strobe_n, 3))
    else $error("load mode entered without reset pin and strobe");
  chk_exit_on_release: assert property (!reset_pin [*4] |=> !load_mode)
    else $error("load mode kept after reset pin released");
  chk_txd_idle_reset: assert property ($fell(reset) |-> txd)
    else $error("serial output not idle after reset");
  chk_oe_in_load: assert property (port0_oe |-> load_mode || $past(load_mode))
    else $error("port 0 driven outside load mode");
  chk_oe_needs_access: assert property (!external_access_sel [*5] |=> !port0_oe)
    else $error("port 0 driven without external access high");
  chk_regs_hold_idle: assert property (!load_mode && !$past(load_mode) |->
      $stable(encryption_key) && $stable(memory_control_reg))
    else $error("registers changed outside load mode");
  cover property ($rose(load_mode));
  cover property ($rose(serial_active));
  cover property ($rose(security_lock));
  cover property (port0_oe);
endmodule
bind program_load_controller program_load_controller_chk u_chk (
  .ref_clk, .reset, .reset_pin, .program_store_strobe_n, .external_access_sel, .txd,
  .port0_oe, .load_mode, .serial_active, .parallel_active, .security_lock,
  .memory_control_reg, .encryption_key);

// file: sim/uart_host.sv
// Host terminal model on the serial loader link
`timescale 1ns/10ps
module uart_host #(
  parameter int BIT = 800
) (
  // Clock and link
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial rxd = 1'b1;
  // Three wires only: no handshake, 8N1, LSB first, idle high
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (BIT) @(posedge ref_clk);
      #1;
    end
  endtask
  // Samples mid-bit so small rate drift in the device is tolerated
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge ref_clk);
      sh[i] = txd;
    end
    repeat (BIT) @(posedge ref_clk);
    rx_q.push_back(sh);
  end
endmodule

// file: sim/tb_program_load_controller.sv
// Self-checking testbench for the program load controller
`timescale 1ns/10ps
module tb_program_load_controller;
  import loader_pkg::*;
  logic        ref_clk, reset, reset_pin, program_store_strobe_n, prog_pulse_n;
  logic        external_access_sel, programming_voltage, rxd, txd, port0_oe;
  logic        load_mode, serial_active, parallel_active, security_lock;
  logic [7:0]  port2_in, port1_in, port0_in, port0_out, memory_control_reg, port_put_value;
  logic [39:0] encryption_key;
  int          failures, n_checks;
  program_load_controller #(.BIT_MAX(2000)) DUT (
    .ref_clk, .reset, .reset_pin, .program_store_strobe_n, .prog_pulse_n,
    .external_access_sel, .programming_voltage, .port2_in, .port1_in, .port0_in,
    .port0_out, .port0_oe, .rxd, .txd, .load_mode, .serial_active, .parallel_active,
    .security_lock, .memory_control_reg, .encryption_key, .port_put_value);
  uart_host #(.BIT(700)) host (.ref_clk, .txd, .rxd);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Address and data settle 4 cycles before the pulse, pulses spaced apart
  task automatic strobe(input logic [7:0] p2, p1, p0, input logic vpp);
    port2_in = p2;
    port1_in = p1;
    port0_in = p0;
    programming_voltage = vpp;
    tick(4);
    prog_pulse_n = 1'b0;
    tick(3);
    prog_pulse_n = 1'b1;
    tick(4);
  endtask
  task automatic verify(input logic [7:0] p2, p1, exp, input string what);
    port2_in = p2;
    port1_in = p1;
    programming_voltage = 1'b0;
    tick(6);
    check(port0_oe, 1'b1, what);
    check(port0_out, exp, what);
  endtask
  task automatic get_char(input logic [7:0] exp, input string what);
    int n;
    n = 0;
    while (host.rx_q.size() == 0 && n < 40000) begin
      tick(1);
      n++;
    end
    if (n >= 40000) begin
      failures++;
      $display("MISMATCH %0t no reply %s", $time, what);
      test_done();
    end else begin
      check(host.rx_q.pop_front(), exp, what);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_parallel;
    reset_pin = 1'b1;
    tick(2);
    program_store_strobe_n = 1'b0;
    tick(4);
    check(load_mode, 1'b1, "load entry");
    external_access_sel = 1'b1;
    strobe(8'h81, 8'h23, 8'hA5, 1'b1);
    check(memory_control_reg, 8'h20, "first strobe init");
    check(parallel_active, 1'b1, "parallel path");
    strobe(8'h81, 8'h23, 8'h3C, 1'b0);
    verify(8'h01, 8'h23, 8'hA5, "program verify");
    strobe(8'h60, 8'h00, 8'h21, 1'b1);
    check(security_lock, 1'b1, "control bit0 lock");
    strobe(8'h60, 8'h00, 8'h20, 1'b1);
    check(security_lock, 1'b0, "lock cleared");
    strobe(8'h60, 8'h05, 8'h5C, 1'b1);
    check(encryption_key[39:32], 8'h5C, "key byte 4");
    verify(8'h60, 8'h00, 8'h20, "control readback");
    strobe(8'h40, 8'h45, 8'h12, 1'b1);
    strobe(8'h40, 8'h45, 8'h77, 1'b1);
    verify(8'h40, 8'h45, 8'h77, "expanded verify");
    strobe(8'hC0, 8'h00, 8'h00, 1'b1);
    check(memory_control_reg, 8'h21, "security set");
  endtask
  task automatic test_serial;
    reset_pin = 1'b0;
    external_access_sel = 1'b0;
    tick(6);
    check(load_mode, 1'b0, "exit on pin");
    port2_in = 8'hFF;
    reset_pin = 1'b1;
    tick(4);
    host.send(CH_CR);
    get_char(CH_PROMPT, "prompt");
    check(serial_active, 1'b1, "serial path");
    host.send(CMD_RMCON);
    host.send(CH_CR);
    get_char(8'h32, "control hi");
    get_char(8'h31, "control lo");
    get_char(CH_PROMPT, "after read");
    host.send(8'h5A);
    host.send(CMD_PUT);
    host.send(8'h35);
    host.send(8'h41);
    host.send(CH_CR);
    get_char(CH_BAD, "unknown cmd");
    get_char(CH_PROMPT, "after put");
    check(port_put_value, 8'h5A, "put value");
  endtask
  initial begin
    reset = 1'b1;
    reset_pin = 1'b0;
    program_store_strobe_n = 1'b1;
    prog_pulse_n = 1'b1;
    external_access_sel = 1'b0;
    programming_voltage = 1'b0;
    port2_in = 8'h00;
    port1_in = 8'h00;
    port0_in = 8'h00;
    tick(6);
    reset = 1'b0;
    tick(3);
    check(txd, 1'b1, "txd idle");
    check(memory_control_reg, MEMORY_CONTROL_REG_RESET, "control reset");
    test_parallel();
    test_serial();
    test_done();
  end
endmodule
